//--- rtl/rstc_consts.svh
/*
  Constants of the reset controller: register offsets, bit positions,
  reset values and timing counts.
  Assumes inclusion by bare name from the design files.
*/
`ifndef RSTC_CONSTS_SVH
`define RSTC_CONSTS_SVH

// ==================================================
// register offsets (16-bit byte address)
`define ADDR_MODE0 16'h0004
`define ADDR_MODE1 16'h0005
`define ADDR_CLKSEL 16'h0006
`define ADDR_PROT 16'h000A
`define ADDR_CAUSE 16'h000B
`define ADDR_OPT2 16'hFFDB
`define ADDR_OPT 16'hFFFF

// ==================================================
// field positions
`define BIT_SOFT_REQ 3
`define BIT_WDOG_SEL 2
`define BIT_UNLOCK 1
`define BIT_CWR 0
`define BIT_HWR 1
`define BIT_SWR 2
`define BIT_WDR 3
`define OPT_UVSEL_LO 4
`define OPT_UVSEL_HI 5
`define OPT_UVSTART 6
`define OPT2_PER_LO 0
`define OPT2_PER_HI 1
`define OPT2_WIN_LO 2
`define OPT2_WIN_HI 3

// ==================================================
// reset values
`define OPT_ERASED 8'hFF
`define CLK_LOWSPEED 2'h0

// ==================================================
// timing counts in core_clk cycles
`define POR_COUNT 6'h20
`define HOLD_CYC 3'h4

`endif

//--- rtl/rstc_pkg.sv
/*
  Types of the reset controller: sequencer states.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package rstc_pkg;

  // ==================================================
  // reset sequencer states
  typedef enum logic [1:0] {
    ST_POWER = 2'b00,
    ST_HOLD = 2'b01,
    ST_RUN = 2'b10
  } seq_state_t;

endpackage

//--- rtl/sync2.sv
/*
  Two-flop synchroniser for levels arriving from pins.
  Assumes a single clock and a synchronous active-high reset.
*/
`timescale 1ns/1ns
module sync2 #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic d,
  output logic q
);

  logic meta_q;

  // ==================================================
  // first stage feeds only the second
  always_ff @(posedge core_clk) begin
    if (srst) begin
      meta_q <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule

//--- rtl/mcu_reset_controller.sv
/*
  Reset controller: merges pin, power-on, undervoltage, watchdog and
  software reset sources into one internal reset, keeps reset-cause
  flags and exposes the nonvolatile option bytes read-only.
  Assumes core_clk is the low-speed on-chip oscillator (25 MHz), srst
  is the power-on reset, and the option bytes are stable levels.
*/
// Overview of operation
// - pin held low keeps everything in reset
// - pin release starts execution at reset vector
// - any reset selects low-speed undivided clock
// - RAM never cleared; interrupted write marks undefined
// - after supply good, count 32 then release
// - enabled undervoltage resets pins, CPU and registers
// - power-on and undervoltage active only if start bit 0
// - threshold and start bits not program-writable
// - watchdog underflow resets when select bit is 1
// - watchdog period and window from option byte
// - writing soft request 1 resets the device
// - warm flag cleared at power-on and undervoltage
// - write 1 sets warm flag; other resets keep it
// - per-source detect flags set on each reset; only pin, soft and watchdog have one
// - writing 0 to warm flag does nothing
// - soft request bit always reads 0
`timescale 1ns/1ns
`include "rstc_consts.svh"
module mcu_reset_controller (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic reset_pin_n,
  input wire logic supply_ok,
  input wire logic wdog_underflow,
  input wire logic ram_wr_busy,
  input wire logic [7:0] nonvolatile_option_byte,
  input wire logic [7:0] nonvolatile_option_byte_two,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_q,
  output logic sys_rst_n_q,
  output logic vector_fetch_q,
  output logic [1:0] clk_src_sel_q,
  output logic [1:0] uv_threshold_sel_q,
  output logic [1:0] wdog_period_sel_q,
  output logic [1:0] wdog_window_sel_q,
  output logic wdog_reset_select_q,
  output logic ram_undefined_q
);

  // ==================================================
  // declarations
  rstc_pkg::seq_state_t state_q;
  rstc_pkg::seq_state_t state_d;
  logic pin_n_s;
  logic supply_s;
  logic [7:0] opt_q;
  logic [7:0] opt2_q;
  logic [5:0] por_cnt_q;
  logic [2:0] hold_cnt_q;
  logic unlock_q;
  logic warm_start_flag_q;
  logic pin_reset_seen_q;
  logic soft_reset_seen_q;
  logic wdog_reset_seen_q;
  logic uv_en;
  logic uv_low;
  logic pin_low;
  logic soft_evt;
  logic wd_evt;
  logic hold_act;
  logic any_src;
  logic cause_wr;

  // ==================================================
  // pin-side synchronisers; pin flops reset to the idle high level, else a false pin reset
  sync2 #(.RST_VAL(1'b1)) u_sync_pin (
    .core_clk(core_clk),
    .srst(srst),
    .d(reset_pin_n),
    .q(pin_n_s)
  );

  sync2 #(.RST_VAL(1'b0)) u_sync_supply (
    .core_clk(core_clk),
    .srst(srst),
    .d(supply_ok),
    .q(supply_s)
  );

  // ==================================================
  // option bytes: captured only while in reset
  // no write path exists, so software can never alter them
  always_ff @(posedge core_clk) begin
    if (srst || !sys_rst_n_q) begin
      opt_q <= nonvolatile_option_byte;
      opt2_q <= nonvolatile_option_byte_two;
    end
  end

  assign uv_threshold_sel_q = {opt_q[`OPT_UVSEL_HI], opt_q[`OPT_UVSEL_LO]};
  assign wdog_period_sel_q = {opt2_q[`OPT2_PER_HI], opt2_q[`OPT2_PER_LO]};
  assign wdog_window_sel_q = {opt2_q[`OPT2_WIN_HI], opt2_q[`OPT2_WIN_LO]};

  // ==================================================
  // reset sources
  // undervoltage and power-on logic live only when start bit is 0
  assign uv_en = ~opt_q[`OPT_UVSTART];
  assign uv_low = uv_en & ~supply_s;
  assign pin_low = ~pin_n_s;

  // unlock gates mode register writes
  assign soft_evt = reg_wr && (reg_addr == `ADDR_MODE0) && reg_wdata[`BIT_SOFT_REQ]
                    && unlock_q && sys_rst_n_q;
  assign wd_evt = wdog_underflow && wdog_reset_select_q && sys_rst_n_q;
  assign hold_act = (hold_cnt_q != 3'h0);
  assign any_src = pin_low | hold_act | soft_evt | wd_evt;
  assign cause_wr = reg_wr && (reg_addr == `ADDR_CAUSE) && sys_rst_n_q;

  // ==================================================
  // hold time for one-cycle sources (soft, watchdog)
  // a pulse alone would give the core too short a reset
  always_ff @(posedge core_clk) begin
    if (srst) begin
      hold_cnt_q <= 3'h0;
    end else if (soft_evt || wd_evt) begin
      hold_cnt_q <= `HOLD_CYC - 3'h1;
    end else if (hold_act) begin
      hold_cnt_q <= hold_cnt_q - 3'h1;
    end
  end

  // ==================================================
  // power-up count: 32 clean cycles of good supply
  always_ff @(posedge core_clk) begin
    if (srst || uv_low || state_q != rstc_pkg::ST_POWER) begin
      por_cnt_q <= 6'h00;
    end else begin
      por_cnt_q <= por_cnt_q + 6'h01;
    end
  end

  // ==================================================
  // sequencer next state
  // undervoltage beats everything, then the ORed sources
  always_comb begin
    state_d = state_q;
    case (state_q)
      rstc_pkg::ST_POWER: begin
        if (!uv_en) begin
          state_d = rstc_pkg::ST_HOLD;
        end else if (!uv_low && por_cnt_q == `POR_COUNT - 6'h01) begin
          state_d = rstc_pkg::ST_HOLD;
        end
      end
      rstc_pkg::ST_HOLD: begin
        if (uv_low) begin
          state_d = rstc_pkg::ST_POWER;
        end else if (!any_src) begin
          state_d = rstc_pkg::ST_RUN;
        end
      end
      rstc_pkg::ST_RUN: begin
        if (uv_low) begin
          state_d = rstc_pkg::ST_POWER;
        end else if (any_src) begin
          state_d = rstc_pkg::ST_HOLD;
        end
      end
      default: begin
        state_d = rstc_pkg::ST_POWER;
      end
    endcase
  end

  // ==================================================
  // sequencer registers; release is always on a clock edge
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_q <= rstc_pkg::ST_POWER;
      sys_rst_n_q <= 1'b0;
      vector_fetch_q <= 1'b0;
    end else begin
      state_q <= state_d;
      sys_rst_n_q <= (state_d == rstc_pkg::ST_RUN);
      vector_fetch_q <= (state_d == rstc_pkg::ST_RUN)
                        && (state_q != rstc_pkg::ST_RUN);
    end
  end

  // ==================================================
  // protect and mode registers: cleared by any reset
  always_ff @(posedge core_clk) begin
    if (srst || !sys_rst_n_q) begin
      unlock_q <= 1'b0;
      wdog_reset_select_q <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == `ADDR_PROT) begin
        unlock_q <= reg_wdata[`BIT_UNLOCK];
      end
      if (reg_wr && reg_addr == `ADDR_MODE1 && unlock_q) begin
        wdog_reset_select_q <= reg_wdata[`BIT_WDOG_SEL];
      end
    end
  end

  // ==================================================
  // clock source select
  // forced back to low-speed undivided during every reset
  always_ff @(posedge core_clk) begin
    if (srst || !sys_rst_n_q) begin
      clk_src_sel_q <= `CLK_LOWSPEED;
    end else if (reg_wr && reg_addr == `ADDR_CLKSEL) begin
      clk_src_sel_q <= reg_wdata[1:0];
    end
  end

  // ==================================================
  // warm-start flag
  // the undervoltage clear wins over a same-cycle write of 1
  always_ff @(posedge core_clk) begin
    if (srst || uv_low) begin
      warm_start_flag_q <= 1'b0;
    end else if (cause_wr && reg_wdata[`BIT_CWR]) begin
      warm_start_flag_q <= 1'b1;
    end
  end

  // ==================================================
  // detect flags: hardware sets, only power-on clears
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pin_reset_seen_q <= 1'b0;
      soft_reset_seen_q <= 1'b0;
      wdog_reset_seen_q <= 1'b0;
    end else begin
      if (pin_low) begin
        pin_reset_seen_q <= 1'b1;
      end
      if (soft_evt) begin
        soft_reset_seen_q <= 1'b1;
      end
      if (wd_evt) begin
        wdog_reset_seen_q <= 1'b1;
      end
    end
  end

  // ==================================================
  // RAM is never cleared; only flag a reset that cut a write
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ram_undefined_q <= 1'b0;
    end else if (sys_rst_n_q && (any_src || uv_low) && ram_wr_busy) begin
      ram_undefined_q <= 1'b1;
    end
  end

  // ==================================================
  // read-back, valid only in the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (srst || !reg_rd) begin
      reg_rdata_q <= 8'h00;
    end else begin
      case (reg_addr)
        `ADDR_MODE0: reg_rdata_q <= 8'h00;
        `ADDR_MODE1: reg_rdata_q <= {5'h00, wdog_reset_select_q, 2'h0};
        `ADDR_CLKSEL: reg_rdata_q <= {6'h00, clk_src_sel_q};
        `ADDR_PROT: reg_rdata_q <= {6'h00, unlock_q, 1'b0};
        `ADDR_CAUSE: reg_rdata_q <= {4'h0, wdog_reset_seen_q, soft_reset_seen_q,
                                      pin_reset_seen_q, warm_start_flag_q};
        `ADDR_OPT: reg_rdata_q <= opt_q;
        `ADDR_OPT2: reg_rdata_q <= opt2_q;
        default: reg_rdata_q <= 8'h00;
      endcase
    end
  end

  // ==================================================
  // assertions
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);

  sequence s_soft_wr;
    soft_evt;
  endsequence

  sequence s_hold_four;
    !sys_rst_n_q [*4] ##1 sys_rst_n_q;
  endsequence

  property p_pin_holds;
    pin_low |=> !sys_rst_n_q;
  endproperty
  a_pin_holds: assert property (p_pin_holds) else $error("pin low without reset");

  property p_vector;
    $rose(sys_rst_n_q) |-> vector_fetch_q;
  endproperty
  a_vector: assert property (p_vector) else $error("release without vector fetch");

  property p_clk_low;
    !sys_rst_n_q |=> clk_src_sel_q == `CLK_LOWSPEED;
  endproperty
  a_clk_low: assert property (p_clk_low) else $error("clock not low-speed");

  property p_por_count;
    $rose(sys_rst_n_q) && $past(state_q, 2) == rstc_pkg::ST_POWER && uv_en
      |-> $past(por_cnt_q, 2) == `POR_COUNT - 6'h01;
  endproperty
  a_por_count: assert property (p_por_count) else $error("power count not 32");

  property p_uv_reset;
    uv_low |=> !sys_rst_n_q && state_q == rstc_pkg::ST_POWER;
  endproperty
  a_uv_reset: assert property (p_uv_reset) else $error("undervoltage missed");

  property p_uv_gate;
    !uv_en && state_q == rstc_pkg::ST_RUN && !any_src |=> sys_rst_n_q;
  endproperty
  a_uv_gate: assert property (p_uv_gate) else $error("disabled monitor reset");

  property p_wdog;
    wd_evt |=> s_hold_four;
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog reset wrong");

  property p_soft;
    s_soft_wr ##0 !wdog_underflow ##1 !pin_low [*4] |-> !sys_rst_n_q;
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset missing");

  property p_soft_len;
    s_soft_wr ##1 (!pin_low && !uv_low && !wdog_underflow) [*5] |-> sys_rst_n_q;
  endproperty
  a_soft_len: assert property (p_soft_len) else $error("soft hold not 4");

  property p_cold;
    uv_low |=> !warm_start_flag_q;
  endproperty
  a_cold: assert property (p_cold) else $error("warm flag not cleared");

  property p_warm_keep;
    (wd_evt || soft_evt) && !uv_low |=> warm_start_flag_q == $past(warm_start_flag_q);
  endproperty
  a_warm_keep: assert property (p_warm_keep) else $error("warm flag changed");

  property p_zero_write;
    cause_wr && !reg_wdata[`BIT_CWR] && warm_start_flag_q && !uv_low
      |=> warm_start_flag_q;
  endproperty
  a_zero_write: assert property (p_zero_write) else $error("zero write cleared");

  property p_seen;
    pin_low |=> pin_reset_seen_q;
  endproperty
  a_seen: assert property (p_seen) else $error("pin flag not set");

  property p_soft_rd;
    reg_rd && reg_addr == `ADDR_MODE0 |=> reg_rdata_q == 8'h00;
  endproperty
  a_soft_rd: assert property (p_soft_rd) else $error("soft bit read 1");

endmodule

//--- verification/reset_supervisor.sv
/*
  Board-side reset supervisor: pull-up on the reset pin plus a switch
  that pulls it low for a fixed time when the bench asks.
  Assumes the bench pulses press for one core_clk cycle.
*/
`timescale 1ns/1ns
module reset_supervisor #(
  parameter int LOW_CYC = 250
) (
  input wire logic core_clk,
  input wire logic press,
  output logic reset_pin_n
);
  int cnt = 0;

  // ==========
  // low time of 250 cycles at 25 MHz is the 10 us minimum
  always @(posedge core_clk) begin
    if (press) begin
      cnt <= LOW_CYC;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end

  // pull-up holds the pin high whenever the switch is open
  assign reset_pin_n = (cnt == 0);
endmodule

//--- verification/tb_mcu_reset_controller.sv
/*
  Testbench of the reset controller: register tasks, a queue of expected
  read data, and one scenario per reset source.
  Assumes the design in rtl/ and the supervisor model beside it.
*/
`timescale 1ns/1ns
`include "rstc_consts.svh"
module tb_mcu_reset_controller;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic supply_ok = 1'b0;
  logic wdog_underflow = 1'b0;
  logic ram_wr_busy = 1'b0;
  logic press = 1'b0;
  logic [7:0] opt = 8'hFF;
  logic [7:0] opt2 = 8'hFF;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic rd_p = 1'b0;
  logic reset_pin_n, sys_rst_n_q, vector_fetch_q, wdog_reset_select_q, ram_undefined_q;
  logic [7:0] reg_rdata_q;
  logic [1:0] clk_src_sel_q, uv_threshold_sel_q, wdog_period_sel_q, wdog_window_sel_q;
  logic [7:0] exp_q[$];
  logic [31:0] seed = 32'h0000_0057;
  int err_count = 0;
  int check_count = 0;
  int n;

  initial begin
    forever #20 core_clk = ~core_clk;
  end

  reset_supervisor u_sup (.core_clk(core_clk), .press(press), .reset_pin_n(reset_pin_n));

  mcu_reset_controller u_dut (
    .core_clk(core_clk), .srst(srst), .reset_pin_n(reset_pin_n), .supply_ok(supply_ok),
    .wdog_underflow(wdog_underflow), .ram_wr_busy(ram_wr_busy),
    .nonvolatile_option_byte(opt), .nonvolatile_option_byte_two(opt2),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q), .sys_rst_n_q(sys_rst_n_q), .vector_fetch_q(vector_fetch_q),
    .clk_src_sel_q(clk_src_sel_q), .uv_threshold_sel_q(uv_threshold_sel_q),
    .wdog_period_sel_q(wdog_period_sel_q), .wdog_window_sel_q(wdog_window_sel_q),
    .wdog_reset_select_q(wdog_reset_select_q), .ram_undefined_q(ram_undefined_q)
  );

  // ==========
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s exp %h seen %h", name, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // expectation is queued by the driver, compared by the monitor below
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge core_clk);
    reg_rd <= 1'b0;
  endtask

  // bounded wait on the internal reset, counted in negedges
  task automatic wait_lvl(input logic lvl, input int max, output int cnt);
    cnt = 0;
    do begin
      @(negedge core_clk);
      cnt++;
    end while (sys_rst_n_q !== lvl && cnt < max);
    if (sys_rst_n_q !== lvl) begin
      check("sys_rst_n_q", {7'h00, sys_rst_n_q}, {7'h00, lvl});
      test_done();
    end
  endtask

  // first cycle out of reset: vector fetch pulse and slow clock
  task automatic released();
    check("vector_fetch", {7'h00, vector_fetch_q}, 8'h01);
    check("clk_sel", {6'h00, clk_src_sel_q}, {6'h00, `CLK_LOWSPEED});
    @(negedge core_clk);
    check("vector_fetch_end", {7'h00, vector_fetch_q}, 8'h00);
  endtask

  // short resets stand for a fixed number of cycles
  task automatic hold_check(input string name);
    wait_lvl(1'b0, 4, n);
    wait_lvl(1'b1, 12, n);
    check(name, 8'(n), 8'(`HOLD_CYC));
    released();
  endtask

  task automatic wdog_pulse();
    @(posedge core_clk);
    wdog_underflow <= 1'b1;
    @(posedge core_clk);
    wdog_underflow <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  always @(posedge core_clk) rd_p <= reg_rd;
  always @(negedge core_clk) begin
    if (rd_p) begin
      if (exp_q.size() == 0) check("read_extra", reg_rdata_q, 8'h00);
      else check("read_data", reg_rdata_q, exp_q.pop_front());
    end
  end

  // ==========
  // scenarios
  initial begin
    seed = xs(seed);
    opt <= seed[7:0] & 8'hBF;
    seed = xs(seed);
    opt2 <= seed[7:0];
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    repeat (6) @(negedge core_clk);
    check("no_supply_hold", {7'h00, sys_rst_n_q}, 8'h00);
    @(posedge core_clk);
    supply_ok <= 1'b1;
    wait_lvl(1'b1, 60, n);
    check("por_count", {7'h00, n >= 32 && n <= 40}, 8'h01);
    released();
    check("uv_sel", {6'h00, uv_threshold_sel_q}, {6'h00, opt[5:4]});
    check("wd_period", {6'h00, wdog_period_sel_q}, {6'h00, opt2[1:0]});
    check("wd_window", {6'h00, wdog_window_sel_q}, {6'h00, opt2[3:2]});
    rd(`ADDR_OPT, opt);
    wr(`ADDR_OPT, ~opt);
    rd(`ADDR_OPT, opt);
    rd(`ADDR_OPT2, opt2);
    rd(16'h0100, 8'h00);
    rd(`ADDR_CAUSE, 8'h00);
    wr(`ADDR_CAUSE, 8'h01);
    rd(`ADDR_CAUSE, 8'h01);
    wr(`ADDR_CAUSE, 8'h00);
    rd(`ADDR_CAUSE, 8'h01);
    // locked mode register: request must be ignored
    wr(`ADDR_MODE0, 8'h08);
    repeat (3) @(negedge core_clk);
    check("locked_soft", {7'h00, sys_rst_n_q}, 8'h01);
    wr(`ADDR_PROT, 8'h02);
    rd(`ADDR_MODE0, 8'h00);
    // fast clock picked before the reset, so the forced return is visible
    wr(`ADDR_CLKSEL, 8'h03);
    rd(`ADDR_CLKSEL, 8'h03);
    wr(`ADDR_MODE0, 8'h08);
    hold_check("soft_hold");
    rd(`ADDR_CAUSE, 8'h05);
    check("ram_clean", {7'h00, ram_undefined_q}, 8'h00);
    // watchdog: ignored until the select bit is set
    wdog_pulse();
    repeat (3) @(negedge core_clk);
    check("wd_ignored", {7'h00, sys_rst_n_q}, 8'h01);
    wr(`ADDR_PROT, 8'h02);
    rd(`ADDR_PROT, 8'h02);
    wr(`ADDR_MODE1, 8'h04);
    @(negedge core_clk);
    check("wd_select", {7'h00, wdog_reset_select_q}, 8'h01);
    rd(`ADDR_MODE1, 8'h04);
    wdog_pulse();
    hold_check("wd_hold");
    rd(`ADDR_CAUSE, 8'h0D);
    // pin reset in the middle of a RAM write
    @(posedge core_clk);
    press <= 1'b1;
    ram_wr_busy <= 1'b1;
    @(posedge core_clk);
    press <= 1'b0;
    wait_lvl(1'b0, 10, n);
    @(posedge core_clk);
    ram_wr_busy <= 1'b0;
    repeat (100) @(negedge core_clk);
    check("pin_held", {7'h00, sys_rst_n_q}, 8'h00);
    wait_lvl(1'b1, 300, n);
    check("pin_len", {7'h00, n >= 140 && n <= 170}, 8'h01);
    released();
    check("ram_undef", {7'h00, ram_undefined_q}, 8'h01);
    rd(`ADDR_CAUSE, 8'h0F);
    // undervoltage: warm flag back to cold, detect flags kept
    @(posedge core_clk);
    supply_ok <= 1'b0;
    wait_lvl(1'b0, 8, n);
    repeat (5) @(posedge core_clk);
    supply_ok <= 1'b1;
    wait_lvl(1'b1, 60, n);
    check("uv_count", {7'h00, n >= 32 && n <= 40}, 8'h01);
    released();
    rd(`ADDR_CAUSE, 8'h0E);
    // start bit set: no wait for the supply
    @(posedge core_clk);
    opt <= opt | 8'h40;
    supply_ok <= 1'b0;
    srst <= 1'b1;
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    wait_lvl(1'b1, 20, n);
    released();
    check("ram_cleared", {7'h00, ram_undefined_q}, 8'h00);
    rd(`ADDR_CAUSE, 8'h00);
    repeat (3) @(posedge core_clk);
    test_done();
  end
endmodule
